// >>> design/rifm_pkg.sv
// shared constants for the remote io field map framer
package rifm_pkg;
  // fieldbus io command code for asynchronous remote io update
  localparam logic [7:0] RIFM_CMD_IO_UPDATE = 8'h50;
  // frame byte numbers
  localparam logic [4:0] RIFM_B_CMD = 5'h01;
  localparam logic [4:0] RIFM_B_OPT0 = 5'h02;
  localparam logic [4:0] RIFM_B_OPT1 = 5'h03;
  localparam logic [4:0] RIFM_B_SLOT0 = 5'h07;
  localparam logic [4:0] RIFM_B_SLOT_LAST = 5'h16;
  localparam logic [4:0] RIFM_B_RADDR = 5'h17;
  localparam logic [4:0] RIFM_B_RCMD = 5'h19;
  localparam logic [4:0] RIFM_B_RDATA = 5'h1b;
  localparam logic [4:0] RIFM_B_LAST = 5'h1f;
  // trigger bit inside the low register command byte
  localparam int RIFM_REGISTER_TRIGGER_BIT = 6;
  // input word bit positions
  localparam int RIFM_IN_SEL0 = 0;
  localparam int RIFM_IN_FWD = 3;
  localparam int RIFM_IN_REV = 4;
  localparam int RIFM_IN_STOP = 5;
  localparam int RIFM_IN_BRAKE = 6;
  // output word bit positions
  localparam int RIFM_OUT_WARN = 6;
  localparam int RIFM_OUT_ALARM = 7;
  localparam int RIFM_OUT_BUSY = 8;
  localparam int RIFM_OUT_MOTION = 12;
  // node address boundary between eight and sixteen axis modes
  localparam logic [3:0] RIFM_ADDR_16AX = 4'h8;
  // line rate selector setting for the converter line rate
  localparam logic [3:0] RIFM_RATE_SEL_625K = 4'h7;
  // timing: one byte is ten line bits at the line rate
  localparam int RIFM_CLK_HZ = 20_000_000;
  localparam int RIFM_LINE_BPS = 625_000;
  localparam int RIFM_BITS_PER_BYTE = 10;
  localparam int RIFM_BYTE_CYCLES = RIFM_CLK_HZ / RIFM_LINE_BPS * RIFM_BITS_PER_BYTE;
  // reset values
  localparam logic [15:0] RIFM_WORD_RST = 16'h0000;
  localparam logic [7:0] RIFM_BYTE_RST = 8'h00;
endpackage : rifm_pkg

// >>> design/rifm_link_if.sv
// byte strobe link between converter end and node end
`timescale 1ns/1ps
interface rifm_link_if;
  logic strb; // command byte strobe, one cycle
  logic [4:0] idx; // frame byte number
  logic [7:0] data; // command byte
  logic rsp_valid; // response byte strobe, one cycle
  logic [4:0] rsp_idx; // frame byte number answered
  logic [7:0] rsp_data; // response byte
  modport conv (output strb, idx, data, input rsp_valid, rsp_idx, rsp_data);
  modport node (input strb, idx, data, output rsp_valid, rsp_idx, rsp_data);
endinterface : rifm_link_if

// >>> design/rifm_node.sv
// node end: picks its slot from the frame, decodes inputs, answers outputs
// Contract
// R1: io update frames use command code 50h
// R2: bytes 1-6 hold the frame header
// R3: bytes 7-22 hold eight ascending two-byte slots
// R4: bytes 23-30 register region, 31 reserved
// R5: default input bit decode, bits 7-15 ignored
// R6: select0 plus forward runs entry 1 speed
// R7: address from rotary low, switch high bit
// R8: integrator gives each node a unique address
// R9: setting switches sampled only at power-up
// R10: connection bit off selects converter control
// R11: rate selector 7 means 625,000 bps
// R12: termination switch on enables 120 ohm
// R13: red error light on link fault
// R14: converter applies enable change after power cycle
// R15: eight-axis 16-bit word, sixteen-axis 8-bit word
// R16: default output word bit layout
// R17: unused inputs ignored, unused outputs low
`timescale 1ns/1ps
module rifm_node
  import rifm_pkg::*;
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst_b, // asynchronous reset, power-up
  rifm_link_if.node link, // link to converter
  input wire logic [3:0] i_addr_rotary, // address rotary value
  input wire logic i_addr_high_bit, // address high switch
  input wire logic i_conn_device_select, // connection device switch
  input wire logic [3:0] i_rate_selector, // line rate selector
  input wire logic i_termination_enable, // termination switch
  input wire logic i_warning_flag, // drive warning
  input wire logic i_alarm_output, // drive alarm
  input wire logic i_system_busy, // drive busy
  input wire logic [3:0] i_motion_status, // alarm2, move, speed reached, torque limit
  output logic [2:0] o_op_select, // operation data select bits
  output logic o_forward_run, // forward run command
  output logic o_reverse_run, // reverse run command
  output logic o_stop_mode, // stop mode command
  output logic o_brake_release, // brake release command
  output logic o_cont_fwd_entry1, // continuous forward at entry 1 speed
  output logic o_termination_on, // 120 ohm termination enabled
  output logic o_converter_mode, // controlled by network converter
  output logic o_comm_err_led // red communication error light
);
  // limits the user of this end must know:
  // switches are read once, on the first edge after reset release
  // a wide word applies only when its high byte arrives
  // answers echo the command applied before this slot
  // the register region passes by untouched
  // whole node state
  typedef struct packed {
    logic cap; // switches captured
    logic [3:0] addr; // captured node address
    logic wide; // eight axis 16-bit mode
    logic conv; // converter mode
    logic term; // termination enable
    logic rate_ok; // line rate setting valid
    logic hdr_ok; // command code of current frame valid
    logic [7:0] lo; // low input byte pending
    logic [6:0] cmd; // decoded input bits 0-6
    logic rsp_valid; // response strobe
    logic [4:0] rsp_idx; // response byte number
    logic [7:0] rsp_data; // response byte
    logic err; // error light
  } rifm_node_t;

  // registered state and the value it takes at the next edge
  rifm_node_t cur;
  rifm_node_t next_cur;
  logic [15:0] out_word; // output word from drive status
  logic [4:0] slot_lo; // byte number of own low byte
  logic in_lo; // strobe on own low byte
  logic in_hi; // strobe on own high byte
  logic code_seen; // strobe on frame byte 1
  logic bad_code; // frame byte 1 with a wrong code

  // output word assembly
  always_comb
  begin
    // start from all low so unused bits never float
    out_word = RIFM_WORD_RST;
    // R16: echoes, warning, alarm, busy, motion
    // echoes show the command already applied, not the one in flight
    out_word[5:0] = {cur.cmd[RIFM_IN_STOP], cur.cmd[RIFM_IN_REV], cur.cmd[RIFM_IN_FWD],
                     cur.cmd[2:0]};
    out_word[RIFM_OUT_WARN] = i_warning_flag;
    out_word[RIFM_OUT_ALARM] = i_alarm_output;
    // R15: sixteen axis mode carries only bits 0-7
    // R17: bits 9-11 and narrow high byte stay low
    // busy and motion only fit the wide word
    if (cur.wide)
    begin
      out_word[RIFM_OUT_BUSY] = i_system_busy;
      out_word[RIFM_OUT_MOTION +: 4] = i_motion_status;
    end
  end

  // slot position by address and mode
  always_comb
  begin
    // R3: slots ascend from byte 7, two bytes each
    // wide nodes take two bytes per address, narrow ones a single byte
    if (cur.wide)
      slot_lo = RIFM_B_SLOT0 + {cur.addr[2:0], 1'b0};
    else
      slot_lo = RIFM_B_SLOT0 + {1'b0, cur.addr};
    // strobes on this node's own slot bytes
    in_lo = link.strb && cur.cap && (link.idx == slot_lo);
    in_hi = link.strb && cur.cap && cur.wide && (link.idx == slot_lo + 5'h01);
    // frame byte 1 and whether it carries a wrong code
    code_seen = link.strb && (link.idx == RIFM_B_CMD);
    bad_code = code_seen && (link.data != RIFM_CMD_IO_UPDATE);
  end

  // next state
  always_comb
  begin
    // hold everything unless a branch below changes it
    next_cur = cur;
    // answer strobe lasts one cycle
    next_cur.rsp_valid = 1'b0;
    // R9: switches taken once after reset release only
    if (!cur.cap)
    begin
      // later switch moves are ignored until the next reset
      next_cur.cap = 1'b1;
      // R7: rotary low nibble, switch as high bit
      next_cur.addr = {i_addr_high_bit, i_addr_rotary[2:0]} |
                      (i_addr_rotary[3] ? RIFM_ADDR_16AX : 4'h0);
      next_cur.addr = i_addr_high_bit ? {1'b1, i_addr_rotary[2:0]} | {i_addr_rotary[3], 3'h0}
                                      : i_addr_rotary;
      // addresses 8 and up run the narrow word
      next_cur.wide = !i_addr_high_bit && !i_addr_rotary[3];
      // R10: switch off selects converter control
      next_cur.conv = !i_conn_device_select;
      // R11: only selector 7 matches the converter rate
      next_cur.rate_ok = (i_rate_selector == RIFM_RATE_SEL_625K);
      // R12: termination follows the switch
      next_cur.term = i_termination_enable;
    end
    // R1: header byte 1 must carry the io update code
    if (link.strb && link.idx == RIFM_B_CMD)
      next_cur.hdr_ok = (link.data == RIFM_CMD_IO_UPDATE);
    // R2: other header bytes carry nothing for the node
    // refused frames leave the command and the answers as they were
    if (cur.hdr_ok && cur.conv && cur.rate_ok)
    begin
      if (in_lo)
      begin
        // answer the low byte in the next cycle
        next_cur.rsp_valid = 1'b1;
        next_cur.rsp_idx = link.idx;
        next_cur.rsp_data = out_word[7:0];
        // R15: narrow word applies on its single byte
        if (!cur.wide)
          next_cur.cmd = link.data[6:0];
        else
          next_cur.lo = link.data;
      end
      if (in_hi)
      begin
        // the high byte completes a wide word
        next_cur.rsp_valid = 1'b1;
        next_cur.rsp_idx = link.idx;
        next_cur.rsp_data = out_word[15:8];
        // R5: bits 0-6 decoded, 7-15 ignored
        // R17: unused input bits dropped here
        next_cur.cmd = cur.lo[6:0];
      end
    end
    // R4: register region bytes 23-30 not acted on here
    // R13: light on bad setting or wrong frame code
    // a wrong code stays lit until the next byte 1 is seen
    next_cur.err = cur.cap && (!cur.rate_ok || !cur.conv || bad_code ||
                   (cur.err && !code_seen));
  end

  // state register
  // a reset acts as a power cycle: switches are read again after it
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // outputs from state
  // link answer
  assign link.rsp_valid = cur.rsp_valid;
  assign link.rsp_idx = cur.rsp_idx;
  assign link.rsp_data = cur.rsp_data;
  // decoded command bits
  assign o_op_select = cur.cmd[2:0];
  assign o_forward_run = cur.cmd[RIFM_IN_FWD];
  assign o_reverse_run = cur.cmd[RIFM_IN_REV];
  assign o_stop_mode = cur.cmd[RIFM_IN_STOP];
  assign o_brake_release = cur.cmd[RIFM_IN_BRAKE];
  // opposing run bits must not start the entry 1 forward run
  // R6: select value 1 with forward runs entry 1
  assign o_cont_fwd_entry1 = (cur.cmd[2:0] == 3'h1) && cur.cmd[RIFM_IN_FWD] &&
                             !cur.cmd[RIFM_IN_REV];
  // settings taken at power-up, and the error light
  assign o_termination_on = cur.term;
  assign o_converter_mode = cur.conv;
  assign o_comm_err_led = cur.err;
endmodule : rifm_node

// >>> design/rifm_conv.sv
// converter end: sends the command frame, gathers slot responses
`timescale 1ns/1ps
module rifm_conv
  import rifm_pkg::*;
#(
  parameter int BYTE_CYCLES = RIFM_BYTE_CYCLES // clocks per line byte
)
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst_b, // asynchronous reset, power-up
  rifm_link_if.conv link, // link to nodes
  input wire logic [7:0] i_comm_enable, // per-slot communication enable
  input wire logic i_start, // send one frame, pulse
  input wire logic [15:0] i_option, // header option field
  input wire logic [127:0] i_in_words, // slot words, address 0 in low bits
  input wire logic [15:0] i_reg_addr, // register address number
  input wire logic [15:0] i_reg_cmd, // register command code with trigger
  input wire logic [31:0] i_reg_data, // register data
  output logic o_busy, // frame in progress
  output logic o_done, // frame finished, pulse
  output logic [7:0] o_resp_code, // response command echo
  output logic [127:0] o_out_words, // gathered slot words
  output logic [7:0] o_conn_status, // slots answered in last frame
  output logic o_comm_err_led // red communication error light
);
  // elaboration check: the ten-bit divider holds at most 1023 counts
  if (BYTE_CYCLES < 4 || BYTE_CYCLES > 1023)
  begin : gen_bad_byte_cycles
    $error("rifm_conv: BYTE_CYCLES out of range");
  end

  typedef enum {RIFM_IDLE, RIFM_SEND, RIFM_TAIL} rifm_state_t;

  // whole converter state
  typedef struct packed {
    rifm_state_t st; // sequencer state
    logic cap; // enable setting captured
    logic [7:0] en; // captured enables
    logic [9:0] div; // byte rate divider
    logic [4:0] idx; // next byte number
    logic [15:0] opt; // latched option
    logic [127:0] inw; // latched slot words
    logic [15:0] raddr; // latched register address
    logic [15:0] rcmd; // latched register command
    logic [31:0] rdata; // latched register data
    logic strb; // link strobe
    logic [4:0] lidx; // link byte number
    logic [7:0] ldata; // link byte
    logic [127:0] outw; // gathered words
    logic [7:0] seen; // slots answered
    logic [7:0] conn; // last frame slots answered
    logic [7:0] code; // response code
    logic done; // done pulse
    logic err; // error light
  } rifm_conv_t;

  rifm_conv_t cur;
  rifm_conv_t next_cur;

  // byte of the command frame at a given position
  function automatic logic [7:0] rifm_frame_byte(input rifm_conv_t s, input logic [4:0] n);
    logic [4:0] k;
    k = n - RIFM_B_SLOT0;
    rifm_frame_byte = RIFM_BYTE_RST;
    // R1: first byte carries the io update code
    if (n == RIFM_B_CMD)
      rifm_frame_byte = RIFM_CMD_IO_UPDATE;
    // R2: option in header, rest of header reserved zero
    else if (n == RIFM_B_OPT0)
      rifm_frame_byte = s.opt[7:0];
    else if (n == RIFM_B_OPT1)
      rifm_frame_byte = s.opt[15:8];
    // R3: slot bytes, low byte first
    else if (n >= RIFM_B_SLOT0 && n <= RIFM_B_SLOT_LAST)
      rifm_frame_byte = s.inw[{k[3:0], 3'h0} +: 8];
    // R4: register address, command, data; byte 31 zero
    else if (n >= RIFM_B_RADDR && n < RIFM_B_RCMD)
      // odd byte carries the high half
      rifm_frame_byte = s.raddr[{n[0], 3'h0} +: 8];
    else if (n >= RIFM_B_RCMD && n < RIFM_B_RDATA)
      rifm_frame_byte = s.rcmd[{n[0], 3'h0} +: 8];
    else if (n >= RIFM_B_RDATA && n < RIFM_B_LAST)
      // byte 27 most significant down to byte 30
      rifm_frame_byte = s.rdata[{2'h2 - n[1:0], 3'h0} +: 8];
  endfunction : rifm_frame_byte

  // next state
  always_comb
  begin
    logic [4:0] k;
    k = link.rsp_idx - RIFM_B_SLOT0;
    next_cur = cur;
    next_cur.strb = 1'b0;
    next_cur.done = 1'b0;
    // R14: enables taken once after reset release only
    if (!cur.cap)
    begin
      next_cur.cap = 1'b1;
      next_cur.en = i_comm_enable;
    end
    // gather slot answers whenever they arrive
    if (link.rsp_valid && link.rsp_idx >= RIFM_B_SLOT0 && link.rsp_idx <= RIFM_B_SLOT_LAST)
    begin
      next_cur.outw[{k[3:0], 3'h0} +: 8] = link.rsp_data;
      next_cur.seen[k[3:1]] = 1'b1;
    end
    case (cur.st)
      RIFM_IDLE:
      begin
        // latch the frame so it cannot change mid send
        if (i_start && cur.cap)
        begin
          next_cur.st = RIFM_SEND;
          next_cur.opt = i_option;
          next_cur.inw = i_in_words;
          next_cur.raddr = i_reg_addr;
          next_cur.rcmd = i_reg_cmd;
          next_cur.rdata = i_reg_data;
          next_cur.rcmd[RIFM_REGISTER_TRIGGER_BIT] = i_reg_cmd[RIFM_REGISTER_TRIGGER_BIT];
          next_cur.idx = RIFM_B_CMD;
          next_cur.div = '0;
          next_cur.seen = '0;
        end
      end
      RIFM_SEND:
      begin
        // one byte per line byte time
        if (cur.div == 10'(BYTE_CYCLES - 1))
        begin
          next_cur.div = '0;
          next_cur.strb = 1'b1;
          next_cur.lidx = cur.idx;
          next_cur.ldata = rifm_frame_byte(cur, cur.idx);
          next_cur.idx = cur.idx + 5'h01;
          if (cur.idx == RIFM_B_LAST)
            next_cur.st = RIFM_TAIL;
        end
        else
          next_cur.div = cur.div + 10'h001;
      end
      RIFM_TAIL:
      begin
        // answers land one cycle after their slot byte strobe, long before the last strobe
        next_cur.st = RIFM_IDLE;
        next_cur.done = 1'b1;
        next_cur.conn = cur.seen;
        next_cur.code = RIFM_CMD_IO_UPDATE;
        // R13: light when an enabled slot stayed silent
        next_cur.err = |(cur.en & ~cur.seen);
      end
      default:
        next_cur.st = RIFM_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign link.strb = cur.strb;
  assign link.idx = cur.lidx;
  assign link.data = cur.ldata;
  assign o_busy = (cur.st != RIFM_IDLE);
  assign o_done = cur.done;
  assign o_resp_code = cur.code;
  assign o_out_words = cur.outw;
  assign o_conn_status = cur.conn;
  assign o_comm_err_led = cur.err;
endmodule : rifm_conv

// >>> bench/rifm_checker.sv
// checker of the link between converter end and node end
`timescale 1ns/1ps
module rifm_checker
  import rifm_pkg::*;
#(
  parameter int BYTE_CYCLES = RIFM_BYTE_CYCLES // clocks per line byte
)
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst_b, // asynchronous reset
  input wire logic strb, // command byte strobe
  input wire logic [4:0] idx, // command byte number
  input wire logic [7:0] data, // command byte
  input wire logic rsp_valid, // answer strobe
  input wire logic [4:0] rsp_idx // answered byte number
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  // cycles since last strobe; saturates so long idle never wraps
  logic [15:0] gap;
  // byte number of last strobe
  logic [4:0] last_idx;
  // spacing helper
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      gap <= 16'h0000;
      last_idx <= 5'h00;
    end
    else if (strb)
    begin
      gap <= 16'h0001;
      last_idx <= idx;
    end
    else if (gap != 16'h0000 && gap != 16'hffff)
    begin
      gap <= gap + 16'h0001;
    end
  end
  // frame opening byte
  sequence open_byte_s;
    strb && idx == RIFM_B_CMD;
  endsequence
  // any later byte
  sequence later_byte_s;
    strb && idx != RIFM_B_CMD;
  endsequence
  code_byte_a: assert property (open_byte_s |-> data == RIFM_CMD_IO_UPDATE)
    else $error("bad command code byte");
  hdr_zero_a: assert property (
    strb && idx inside {5'h04, 5'h05, 5'h06} |-> data == 8'h00)
    else $error("reserved header byte not zero");
  tail_zero_a: assert property (strb && idx == RIFM_B_LAST |-> data == 8'h00)
    else $error("last frame byte not zero");
  byte_order_a: assert property (
    later_byte_s |-> gap == BYTE_CYCLES && idx == last_idx + 5'h01)
    else $error("frame byte out of order or spacing");
  strb_pulse_a: assert property (strb |=> !strb)
    else $error("strobe longer than one cycle");
  rsp_slot_a: assert property (
    rsp_valid |-> rsp_idx inside {[RIFM_B_SLOT0:RIFM_B_SLOT_LAST]})
    else $error("answer outside slot bytes");
  rsp_time_a: assert property (rsp_valid |-> $past(strb) && rsp_idx == $past(idx))
    else $error("answer not one cycle after strobe");
  cmd_hold_a: assert property (!strb |-> $stable(idx) && $stable(data))
    else $error("command byte moved between strobes");
endmodule : rifm_checker

// >>> bench/testbench.sv
// self-checking bench: converter end and node end on one link
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  import rifm_pkg::*;
  // one row: slot 0 stimulus beside expected answer
  typedef struct packed {
    logic [15:0] in_word; // slot 0 command word
    logic [6:0] stat; // motion, busy, alarm, warning
    logic [15:0] exp_out; // slot 0 answer word
    logic [6:0] exp_cmd; // brake, stop, rev, fwd, select
    logic exp_cont; // entry 1 forward run
  } rifm_row_t;
  logic i_ref_clk, i_rst_b, i_start, i_conn_device_select, i_termination_enable;
  logic i_warning_flag, i_alarm_output, i_system_busy, i_addr_high_bit;
  logic [3:0] i_addr_rotary, i_rate_selector, i_motion_status;
  logic [7:0] i_comm_enable, o_resp_code, o_conn_status;
  logic [127:0] i_in_words, o_out_words;
  logic [2:0] o_op_select;
  logic o_forward_run, o_reverse_run, o_stop_mode, o_brake_release, o_cont_fwd_entry1;
  logic o_termination_on, o_converter_mode, node_err, conv_err, o_busy, o_done;
  int miscompares, check_count, extra;
  // node command in input word bit order
  logic [6:0] cmd;
  assign cmd = {o_brake_release, o_stop_mode, o_reverse_run, o_forward_run, o_op_select};
  // plain cases; other slots hold run bits that must not leak in
  // answer echo bits show the command of the row before
  rifm_row_t rows [4] = '{
    '{16'h0009, 7'h00, 16'h0000, 7'h09, 1'b1},
    '{16'hff80, 7'h7f, 16'hf1c9, 7'h00, 1'b0},
    '{16'h0079, 7'h05, 16'h0140, 7'h79, 1'b0},
    '{16'h000a, 7'h12, 16'h20b9, 7'h0a, 1'b0}
  };
  rifm_link_if link();
  // short byte time keeps frames at about 250 clocks
  rifm_conv #(.BYTE_CYCLES(8)) rifm_conv_inst (.i_ref_clk, .i_rst_b, .link(link),
    .i_comm_enable, .i_start, .i_option(16'h1234), .i_in_words, .i_reg_addr(16'h0102),
    .i_reg_cmd(16'h0040), .i_reg_data(32'h0a0b0c0d), .o_busy, .o_done, .o_resp_code,
    .o_out_words, .o_conn_status, .o_comm_err_led(conv_err));
  rifm_node rifm_node_inst (.i_ref_clk, .i_rst_b, .link(link), .i_addr_rotary,
    .i_addr_high_bit, .i_conn_device_select, .i_rate_selector, .i_termination_enable,
    .i_warning_flag, .i_alarm_output, .i_system_busy, .i_motion_status, .o_op_select,
    .o_forward_run, .o_reverse_run, .o_stop_mode, .o_brake_release, .o_cont_fwd_entry1,
    .o_termination_on, .o_converter_mode, .o_comm_err_led(node_err));
  rifm_checker #(.BYTE_CYCLES(8)) rifm_checker_inst (.i_ref_clk, .i_rst_b,
    .strb(link.strb), .idx(link.idx), .data(link.data), .rsp_valid(link.rsp_valid),
    .rsp_idx(link.rsp_idx));
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // power-up with given switches; they are sampled only here
  task automatic do_reset(input logic [3:0] rot, input logic [3:0] rate, input logic sel,
                          input logic term);
    i_rst_b = 1'b0;
    i_addr_rotary = rot;
    i_addr_high_bit = 1'b0;
    i_rate_selector = rate;
    i_conn_device_select = sel;
    i_termination_enable = term;
    repeat (8) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (2) @(negedge i_ref_clk);
  endtask : do_reset
  // one cycle start request
  task automatic pulse_start;
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
  endtask : pulse_start
  // bounded wait for frame end
  task automatic wait_done;
    int n = 0;
    `CHK(o_busy, 1'b1)
    while (o_done !== 1'b1 && n < 400)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    if (o_done !== 1'b1)
    begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_done
  // whole frame
  task automatic run_frame;
    pulse_start();
    wait_done();
  endtask : run_frame
  // 20 MHz clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  // main sequence
  initial
  begin
    miscompares = 0;
    check_count = 0;
    i_start = 1'b0;
    i_comm_enable = 8'h01;
    i_in_words = '0;
    {i_motion_status, i_system_busy, i_alarm_output, i_warning_flag} = 7'h00;
    // one node per link, so each address is unique
    do_reset(4'h0, RIFM_RATE_SEL_625K, 1'b0, 1'b0);
    `CHK(o_resp_code, 8'h00)
    `CHK(o_busy, 1'b0)
    `CHK(o_converter_mode, 1'b1)
    `CHK(o_termination_on, 1'b0)
    $display("reset test done");
    foreach (rows[n])
    begin
      {i_motion_status, i_system_busy, i_alarm_output, i_warning_flag} = rows[n].stat;
      i_in_words = {{7{16'h0018}}, rows[n].in_word};
      run_frame();
      `CHK(cmd, rows[n].exp_cmd)
      `CHK(o_cont_fwd_entry1, rows[n].exp_cont)
      `CHK(o_out_words[15:0], rows[n].exp_out)
      `CHK(o_resp_code, RIFM_CMD_IO_UPDATE)
      `CHK(o_conn_status, 8'h01)
      `CHK(conv_err, 1'b0)
      $display("row %0d done", n);
    end
    // sixteen-axis node at address 10 reads low byte of slot 5
    i_comm_enable = 8'h20;
    do_reset(4'ha, RIFM_RATE_SEL_625K, 1'b0, 1'b0);
    {i_motion_status, i_system_busy, i_alarm_output, i_warning_flag} = 7'h01;
    i_in_words = {32'h0, 16'hff09, 80'h0};
    run_frame();
    `CHK(cmd, 7'h09)
    `CHK(o_out_words[87:80], 8'h40)
    `CHK(o_conn_status, 8'h20)
    `CHK(conv_err, 1'b0)
    // switches and enables moved while powered: ignored until next power-up
    i_addr_rotary = 4'h0;
    i_addr_high_bit = 1'b1;
    i_comm_enable = 8'h01;
    i_in_words = {32'h0, 16'h0010, 64'h0, 16'h0009};
    run_frame();
    `CHK(cmd, 7'h10)
    `CHK(o_conn_status, 8'h20)
    `CHK(o_out_words[87:80], 8'h49)
    `CHK(conv_err, 1'b0)
    $display("address test done");
    // wrong rate, other connection device, termination on
    i_comm_enable = 8'h01;
    do_reset(4'h0, 4'h6, 1'b1, 1'b1);
    i_in_words = {112'h0, 16'h0009};
    run_frame();
    `CHK(o_converter_mode, 1'b0)
    `CHK(o_termination_on, 1'b1)
    `CHK(node_err, 1'b1)
    `CHK(cmd, 7'h00)
    `CHK(o_conn_status, 8'h00)
    `CHK(conv_err, 1'b1)
    $display("settings test done");
    // factory settings; a second start in mid-frame is refused
    do_reset(4'h0, RIFM_RATE_SEL_625K, 1'b0, 1'b0);
    pulse_start();
    repeat (20) @(negedge i_ref_clk);
    pulse_start();
    wait_done();
    `CHK(node_err, 1'b0)
    `CHK(cmd, 7'h09)
    extra = 0;
    repeat (300)
    begin
      @(negedge i_ref_clk);
      if (o_busy || o_done)
        extra++;
    end
    `CHK(extra, 0)
    $display("refusal test done");
    print_verdict();
  end
endmodule : testbench
